// ---- common/pfrs_defines.vh ----
`ifndef PFRS_DEFINES_VH
`define PFRS_DEFINES_VH

`define PFRS_ADDR_CTRL       8'h00
`define PFRS_ADDR_START_FREQ 8'h04
`define PFRS_ADDR_OUTAGE_MS  8'h08
`define PFRS_ADDR_STATE      8'h0c
`define PFRS_ADDR_IRQ_STAT   8'h10
`define PFRS_ADDR_IRQ_MASK   8'h14
`define PFRS_ADDR_CMD        8'h18
`define PFRS_ADDR_SAVED_FREQ 8'h1c

`define PFRS_CTRL_MODE_LSB   0
`define PFRS_CTRL_MODE_MSB   2
`define PFRS_CTRL_SMODE_LSB  4
`define PFRS_CTRL_SMODE_MSB  5
`define PFRS_CTRL_VECTOR     8
`define PFRS_CMD_ALARM_RST   0

`define PFRS_EV_ALARM        0
`define PFRS_EV_RESTART      1
`define PFRS_EV_LAPSE        2
`define PFRS_EV_FAIL         3
`define PFRS_EV_W            4

`define PFRS_CTRL_RST        32'h0000_0000
`define PFRS_START_FREQ_RST  16'h0000
`define PFRS_OUTAGE_MS_RST   16'h03e8
`define PFRS_MASK_RST        4'h0

`define PFRS_CLK_HZ          125000000
`define PFRS_TICK_US         1000
`define PFRS_TICK_CYC        ((`PFRS_CLK_HZ / 1000000) * `PFRS_TICK_US)
`define PFRS_RUN_WAIT_MS     16'h07d0

`endif

// ---- hw/pfrs_timer.v ----
`timescale 1ns/10ps
`include "pfrs_defines.vh"
// Millisecond timer; the divider restarts with the count so the
// first tick is a full millisecond after start.
module pfrs_timer #(
    parameter TICK_CYC = `PFRS_TICK_CYC
) (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        start,
    input  wire        run,
    input  wire [15:0] limit,
    output reg         expired
);
    reg [31:0] div;
    reg [15:0] count;
    wire       tick;

    assign tick = (div == TICK_CYC - 1);

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div     <= 32'h0000_0000;
            count   <= 16'h0000;
            expired <= 1'b0;
        end
        else if (start)
        begin
            div     <= 32'h0000_0000;
            count   <= 16'h0000;
            expired <= 1'b0;
        end
        else if (run && !expired)
        begin
            div <= tick ? 32'h0000_0000 : div + 32'h0000_0001;
            if (tick)
            begin
                count <= count + 16'h0001;
                if (count + 16'h0001 >= limit)
                    expired <= 1'b1;
            end
        end
    end
endmodule

// ---- hw/pfrs_main.v ----
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "pfrs_defines.vh"
module pfrs_main #(
    parameter TICK_CYC = `PFRS_TICK_CYC,
    parameter FW       = 16
) (
    input  wire          clk_sys,
    input  wire          sys_rst,
    input  wire [7:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [31:0]   reg_rdata,
    input  wire          undervoltage_det,
    input  wire          cont_run_det,
    input  wire          run_cmd,
    input  wire          coast_stop_input,
    input  wire          power_fail_interlock_input,
    input  wire          speed_search_enable_input,
    input  wire          decel_done,
    input  wire          search_done,
    input  wire [FW-1:0] output_freq,
    input  wire [FW-1:0] search_freq,
    output wire          output_enable,
    output wire          decel_active,
    output wire          cont_run_active,
    output wire          search_start,
    output reg           restart_go,
    output reg  [FW-1:0] restart_freq,
    output wire          undervoltage_alarm,
    output wire          irq
);
    localparam [6:0] ST_RUN    = 7'h01;
    localparam [6:0] ST_ALARM  = 7'h02;
    localparam [6:0] ST_COAST  = 7'h04;
    localparam [6:0] ST_DECEL  = 7'h08;
    localparam [6:0] ST_CONT   = 7'h10;
    localparam [6:0] ST_WAIT   = 7'h20;
    localparam [6:0] ST_SEARCH = 7'h40;

    localparam [2:0] MODE_ALARM   = 3'h0;
    localparam [2:0] MODE_LATE    = 3'h1;
    localparam [2:0] MODE_DECEL   = 3'h2;
    localparam [2:0] MODE_CONT    = 3'h3;
    localparam [2:0] MODE_SAVED   = 3'h4;
    localparam [2:0] MODE_STARTF  = 3'h5;

    reg  [31:0]           ctrl;
    reg  [15:0]           start_freq;
    reg  [15:0]           outage_ms;
    wire [`PFRS_EV_W-1:0] irq_stat;
    reg  [`PFRS_EV_W-1:0] irq_mask;
    reg  [6:0]            state;
    reg  [6:0]            next_state;
    reg  [FW-1:0]         saved_freq;
    reg                   abandon;
    reg                   search_req;
    reg                   fail_seen;
    reg  [`PFRS_EV_W-1:0] ev;

    wire [2:0] mode;
    wire [1:0] smode;
    wire       vector;
    wire       fail;
    wire       search_en;
    wire       restart_mode;
    wire       wait_exp;
    wire       outage_exp;
    wire       wr_cmd;
    wire       alarm_rst;
    wire       stat_wr;

    assign mode   = ctrl[`PFRS_CTRL_MODE_MSB:`PFRS_CTRL_MODE_LSB];
    assign smode  = ctrl[`PFRS_CTRL_SMODE_MSB:`PFRS_CTRL_SMODE_LSB];
    assign vector = ctrl[`PFRS_CTRL_VECTOR];

    // Interlock catches outages the bus voltage alone would miss
    assign fail = undervoltage_det | power_fail_interlock_input;

    assign search_en = speed_search_enable_input | (smode == 2'h1) | (smode == 2'h2);

    assign restart_mode = (mode == MODE_CONT) | (mode == MODE_SAVED) | (mode == MODE_STARTF);

    assign wr_cmd    = reg_wr && (reg_addr == `PFRS_ADDR_CMD);
    assign alarm_rst = wr_cmd && reg_wdata[`PFRS_CMD_ALARM_RST];
    assign stat_wr   = reg_wr && (reg_addr == `PFRS_ADDR_IRQ_STAT);

    pfrs_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_run_wait (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .start    (state != ST_WAIT),
        .run      (state == ST_WAIT),
        .limit    (`PFRS_RUN_WAIT_MS),
        .expired  (wait_exp)
    );

    // Outage clock runs from failure recognition through the wait
    pfrs_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_outage (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .start    (!fail_seen),
        .run      (fail_seen),
        .limit    (outage_ms),
        .expired  (outage_exp)
    );

    always @*
    begin
        next_state = state;
        ev         = {`PFRS_EV_W{1'b0}};
        case (state)
            ST_RUN:
            begin
                if (fail && (mode == MODE_ALARM))
                begin
                    next_state      = ST_ALARM;
                    ev[`PFRS_EV_ALARM] = 1'b1;
                    ev[`PFRS_EV_FAIL]  = 1'b1;
                end
                else if ((mode == MODE_DECEL) && (cont_run_det || fail))
                begin
                    next_state     = ST_DECEL;
                    ev[`PFRS_EV_FAIL] = 1'b1;
                end
                else if ((mode == MODE_CONT) && !vector && cont_run_det && !fail)
                    next_state = ST_CONT;
                else if (fail)
                begin
                    // Modes 1, 3, 4, 5 and unused codes all coast
                    next_state     = ST_COAST;
                    ev[`PFRS_EV_FAIL] = 1'b1;
                end
            end
            ST_CONT:
            begin
                if (fail)
                begin
                    next_state     = ST_COAST;
                    ev[`PFRS_EV_FAIL] = 1'b1;
                end
                else if (!cont_run_det)
                    next_state = ST_RUN;
            end
            ST_DECEL:
            begin
                if (decel_done)
                begin
                    next_state      = ST_ALARM;
                    ev[`PFRS_EV_ALARM] = 1'b1;
                end
            end
            ST_COAST:
            begin
                if (!fail)
                begin
                    if (mode == MODE_LATE)
                    begin
                        next_state      = ST_ALARM;
                        ev[`PFRS_EV_ALARM] = 1'b1;
                    end
                    // Coast request in the last outage cycle also abandons
                    else if (restart_mode && !abandon && !coast_stop_input)
                        next_state = ST_WAIT;
                    else
                        next_state = ST_RUN;
                end
            end
            ST_WAIT:
            begin
                if (fail)
                    next_state = ST_COAST;
                else if (outage_exp || wait_exp)
                begin
                    next_state      = ST_RUN;
                    ev[`PFRS_EV_LAPSE] = 1'b1;
                end
                else if (run_cmd && search_en)
                    next_state = ST_SEARCH;
                else if (run_cmd)
                begin
                    next_state        = ST_RUN;
                    ev[`PFRS_EV_RESTART] = 1'b1;
                end
            end
            ST_SEARCH:
            begin
                if (fail)
                    next_state = ST_COAST;
                else if (!run_cmd)
                    next_state = ST_RUN;
                else if (search_done)
                begin
                    next_state        = ST_RUN;
                    ev[`PFRS_EV_RESTART] = 1'b1;
                end
            end
            ST_ALARM:
            begin
                if (alarm_rst && !fail)
                    next_state = ST_RUN;
            end
            default:
                next_state = ST_RUN;
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state        <= ST_RUN;
            saved_freq   <= {FW{1'b0}};
            abandon      <= 1'b0;
            fail_seen    <= 1'b0;
            search_req   <= 1'b0;
            restart_go   <= 1'b0;
            restart_freq <= {FW{1'b0}};
        end
        else
        begin
            state      <= next_state;
            restart_go <= ev[`PFRS_EV_RESTART];
            search_req <= (state == ST_WAIT) && (next_state == ST_SEARCH);
            // Frequency at the moment output is cut, for mode 3 and 4 restart
            if ((state == ST_RUN || state == ST_CONT) && next_state == ST_COAST)
                saved_freq <= output_freq;
            if (ev[`PFRS_EV_FAIL] || (state == ST_CONT && next_state == ST_COAST))
                fail_seen <= 1'b1;
            else if (next_state == ST_RUN || next_state == ST_ALARM)
                fail_seen <= 1'b0;
            if (state == ST_COAST && coast_stop_input)
                abandon <= 1'b1;
            else if (state != ST_COAST)
                abandon <= 1'b0;
            if (ev[`PFRS_EV_RESTART])
            begin
                if (state == ST_SEARCH)
                    restart_freq <= search_freq;
                else if (mode == MODE_STARTF)
                    restart_freq <= start_freq[FW-1:0];
                else
                    restart_freq <= saved_freq;
            end
        end
    end

    assign search_start    = search_req;
    assign decel_active    = (state == ST_DECEL);
    assign cont_run_active = (state == ST_CONT);
    // Output is off in coast, wait, search and alarm states; decel and continuous run keep driving
    assign output_enable = ((state == ST_RUN) && run_cmd && !coast_stop_input && !fail)
                         | decel_active | cont_run_active;
    assign undervoltage_alarm = (state == ST_ALARM);
    assign irq = |(irq_stat & irq_mask);

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl       <= `PFRS_CTRL_RST;
            start_freq <= `PFRS_START_FREQ_RST;
            outage_ms  <= `PFRS_OUTAGE_MS_RST;
            irq_mask   <= `PFRS_MASK_RST;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `PFRS_ADDR_CTRL:       ctrl       <= reg_wdata;
                    `PFRS_ADDR_START_FREQ: start_freq <= reg_wdata[15:0];
                    `PFRS_ADDR_OUTAGE_MS:  outage_ms  <= reg_wdata[15:0];
                    `PFRS_ADDR_IRQ_MASK:   irq_mask   <= reg_wdata[`PFRS_EV_W-1:0];
                    default:               ;
                endcase
            end
        end
    end

    // One sticky flag per event; a new event wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < `PFRS_EV_W; gi = gi + 1)
        begin : g_stat
            reg flag;
            always @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                    flag <= 1'b0;
                else if (ev[gi])
                    flag <= 1'b1;
                else if (stat_wr && reg_wdata[gi])
                    flag <= 1'b0;
            end
            assign irq_stat[gi] = flag;
        end
    endgenerate

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PFRS_ADDR_CTRL:       reg_rdata <= {23'h0, ctrl[8], 2'h0, ctrl[5:4], 1'b0, ctrl[2:0]};
                `PFRS_ADDR_START_FREQ: reg_rdata <= {16'h0000, start_freq};
                `PFRS_ADDR_OUTAGE_MS:  reg_rdata <= {16'h0000, outage_ms};
                `PFRS_ADDR_STATE:      reg_rdata <= {20'h00000, abandon, fail_seen, search_en, fail, 1'b0, state};
                `PFRS_ADDR_IRQ_STAT:   reg_rdata <= {28'h0000000, irq_stat};
                `PFRS_ADDR_IRQ_MASK:   reg_rdata <= {28'h0000000, irq_mask};
                `PFRS_ADDR_SAVED_FREQ: reg_rdata <= {{(32-FW){1'b0}}, saved_freq};
                default:               reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule

// ---- testbench/pfrs_monitor.sv ----
`timescale 1ns/10ps
module pfrs_monitor #(
    parameter FW = 16
) (
    input logic          clk_sys,
    input logic          sys_rst,
    input logic [7:0]    reg_addr,
    input logic          reg_wr,
    input logic          undervoltage_det,
    input logic          power_fail_interlock_input,
    input logic          run_cmd,
    input logic          decel_done,
    input logic          output_enable,
    input logic          decel_active,
    input logic          cont_run_active,
    input logic          search_start,
    input logic          restart_go,
    input logic [FW-1:0] restart_freq,
    input logic          undervoltage_alarm
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    alarm_hold_a: assert property (undervoltage_alarm && !(reg_wr && reg_addr == 8'h18)
        |=> undervoltage_alarm) else $error("alarm dropped");
    alarm_no_drive_a: assert property (undervoltage_alarm |-> !output_enable)
        else $error("drive during alarm");
    fail_no_drive_a: assert property ((undervoltage_det || power_fail_interlock_input) && !decel_active
        && !cont_run_active |-> !output_enable) else $error("drive during outage");
    go_pulse_a: assert property (restart_go |=> !restart_go)
        else $error("restart pulse too long");
    freq_with_go_a: assert property (!$stable(restart_freq) |-> restart_go)
        else $error("freq moved");
    go_needs_run_a: assert property (restart_go |-> $past(run_cmd))
        else $error("restart unasked");
    search_pulse_a: assert property (search_start |=> !search_start)
        else $error("search pulse long");
    decel_drive_a: assert property (decel_active |-> output_enable && !undervoltage_alarm)
        else $error("decel not driving");
    decel_alarm_a: assert property ($rose(undervoltage_alarm) && $past(decel_active) |-> $past(decel_done))
        else $error("alarm before stop");
    cover property ($rose(undervoltage_alarm));
    cover property (restart_go);
    cover property (search_start);
endmodule

// ---- testbench/pfrs_stage.sv ----
`timescale 1ns/10ps
module pfrs_stage (
    input  logic        clk_sys,
    input  logic        sys_rst,
    input  logic        decel_active,
    input  logic        search_start,
    input  logic [15:0] freq_in,
    input  logic [3:0]  lag,
    output logic [15:0] output_freq,
    output logic [15:0] search_freq,
    output logic        decel_done,
    output logic        search_done
);
    logic [4:0] dcnt, scnt;
    logic       busy, tog;
    assign output_freq = freq_in;
    // Result only meaningful with done, so it toggles otherwise
    assign search_freq = search_done ? freq_in ^ 16'h5a5a : {16{tog}};
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            {dcnt, scnt, busy, tog, decel_done, search_done} <= '0;
        else
        begin
            tog <= ~tog;
            // Braking takes lag+1 cycles of regeneration
            dcnt <= decel_active ? dcnt + 5'd1 : 5'd0;
            decel_done <= decel_active && dcnt >= {1'b0, lag};
            busy <= search_start | (busy & ~search_done);
            scnt <= busy ? scnt + 5'd1 : 5'd0;
            search_done <= busy && scnt == {1'b0, lag};
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, run_cmd = 0, undervoltage_det = 0;
    logic        cont_run_det = 0, coast_stop_input = 0, power_fail_interlock_input = 0;
    logic        speed_search_enable_input = 0, decel_done, search_done, output_enable, decel_active;
    logic        cont_run_active, search_start, restart_go, undervoltage_alarm, irq;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, d, x = 3;
    logic [15:0] output_freq, search_freq, restart_freq, freq_in = 0, sf, fr;
    logic [3:0]  lag = 0;
    logic [31:0] ctl [5] = '{32'h4, 32'h5, 32'h4, 32'h15, 32'h24};
    int          bad_count = 0, n_checks = 0, gos = 0, i;
    pfrs_main #(.TICK_CYC(4)) u_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .undervoltage_det, .cont_run_det, .run_cmd, .coast_stop_input, .power_fail_interlock_input,
        .speed_search_enable_input, .decel_done, .search_done, .output_freq, .search_freq, .output_enable,
        .decel_active, .cont_run_active, .search_start, .restart_go, .restart_freq, .undervoltage_alarm, .irq);
    pfrs_stage u_stage (.clk_sys, .sys_rst, .decel_active, .search_start, .freq_in, .lag, .output_freq,
        .search_freq, .decel_done, .search_done);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) gos <= gos + (restart_go === 1'b1);
    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic [15:0] want(logic [2:0] m, logic s, logic [15:0] sv, logic [15:0] st, logic [15:0] fd);
        return s ? fd : (m == 3'd5 ? st : sv);
    endfunction
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1;
        tick(1);
        reg_wr <= 0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1;
        tick(1);
        reg_rd <= 0;
        d = reg_rdata;
        tick(1);
    endtask
    task automatic clr();
        wr(8'h18, 1);
        wr(8'h10, 32'hf);
    endtask
    task automatic wait_go(logic [15:0] e);
        for (int k = 0; k < 300 && restart_go !== 1'b1; k++)
            tick(1);
        cmp("restart_go", 1, restart_go);
        cmp("restart_freq", e, restart_freq);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        tick(8);
        sys_rst <= 0;
        tick(1);
        rd(8'h08);
        cmp("outage_ms", 32'h3e8, d);
        rd(8'h40);
        cmp("unmapped", 0, d);
        run_cmd <= 1;
        wr(8'h14, 1);
        power_fail_interlock_input <= 1;
        tick(2);
        cmp("alarm", 1, undervoltage_alarm);
        cmp("drive", 0, output_enable);
        cmp("irq", 1, irq);
        wr(8'h18, 1);
        cmp("alarm", 1, undervoltage_alarm);
        power_fail_interlock_input <= 0;
        clr();
        cmp("irq", 0, irq);
        cmp("drive", 1, output_enable);
        wr(8'h00, 1);
        undervoltage_det <= 1;
        tick(4);
        cmp("alarm", 0, undervoltage_alarm);
        cmp("drive", 0, output_enable);
        undervoltage_det <= 0;
        tick(2);
        cmp("alarm", 1, undervoltage_alarm);
        cmp("drive", 0, output_enable);
        clr();
        wr(8'h00, 2);
        lag <= 4'd9;
        cont_run_det <= 1;
        tick(2);
        cmp("decel", 1, decel_active);
        cmp("drive", 1, output_enable);
        cmp("alarm", 0, undervoltage_alarm);
        tick(20);
        cmp("alarm", 1, undervoltage_alarm);
        cont_run_det <= 0;
        clr();
        wr(8'h00, 32'h103);
        cont_run_det <= 1;
        tick(2);
        cmp("cont_run", 0, cont_run_active);
        undervoltage_det <= 1;
        tick(2);
        cmp("drive", 0, output_enable);
        undervoltage_det <= 0;
        cont_run_det <= 0;
        tick(30);
        // Same mode under V/f keeps driving through the dip
        wr(8'h00, 3);
        cont_run_det <= 1;
        tick(2);
        cmp("cont_run", 1, cont_run_active);
        cmp("drive", 1, output_enable);
        cont_run_det <= 0;
        tick(2);
        cmp("cont_run", 0, cont_run_active);
        for (i = 0; i < 5; i++)
        begin
            d = xs();
            sf = d[15:0];
            fr = d[31:16];
            lag <= d[3:0];
            wr(8'h04, {16'h0, sf});
            wr(8'h00, ctl[i]);
            speed_search_enable_input <= (i == 2);
            freq_in <= fr;
            tick(2);
            undervoltage_det <= 1;
            tick(2);
            cmp("drive", 0, output_enable);
            cmp("alarm", 0, undervoltage_alarm);
            freq_in <= ~fr;
            tick(4);
            undervoltage_det <= 0;
            wait_go(want(ctl[i][2:0], i > 1, fr, sf, ~fr ^ 16'h5a5a));
        end
        speed_search_enable_input <= 0;
        wr(8'h00, 4);
        wr(8'h08, 32'd3000);
        run_cmd <= 0;
        undervoltage_det <= 1;
        tick(4);
        undervoltage_det <= 0;
        tick(7600);
        rd(8'h0c);
        cmp("state", 32'h20, d & 32'h7f);
        cmp("drive", 0, output_enable);
        run_cmd <= 1;
        wait_go(~fr);
        // No run command: the two-second window lapses first
        run_cmd <= 0;
        undervoltage_det <= 1;
        tick(4);
        undervoltage_det <= 0;
        tick(8100);
        rd(8'h10);
        cmp("lapse", 32'h4, d & 32'h4);
        rd(8'h0c);
        cmp("state", 32'h1, d & 32'h7f);
        wr(8'h10, 32'h4);
        wr(8'h08, 32'd100);
        wr(8'h14, 32'h4);
        run_cmd <= 0;
        undervoltage_det <= 1;
        tick(4);
        undervoltage_det <= 0;
        i = gos;
        tick(600);
        cmp("irq", 1, irq);
        cmp("restarts", i, gos);
        run_cmd <= 1;
        tick(2);
        cmp("drive", 1, output_enable);
        undervoltage_det <= 1;
        coast_stop_input <= 1;
        tick(3);
        coast_stop_input <= 0;
        undervoltage_det <= 0;
        i = gos;
        tick(20);
        cmp("restarts", i, gos);
        rd(8'h0c);
        cmp("state", 32'h1, d & 32'h7f);
        cmp("drive", 1, output_enable);
        wrap_up();
    end
endmodule
bind pfrs_main pfrs_monitor #(.FW(FW)) u_mon (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .undervoltage_det,
    .power_fail_interlock_input, .run_cmd, .decel_done, .output_enable, .decel_active, .cont_run_active,
    .search_start, .restart_go, .restart_freq, .undervoltage_alarm);
